// ===== hw/atc_pkg.sv
package atc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CHAN_CTRL_0   = 8'h00;
  localparam logic [7:0] OFF_CHAN_CTRL_1   = 8'h04;
  localparam logic [7:0] OFF_TIMING_CFG_1  = 8'h08;
  localparam logic [7:0] OFF_TIMING_CFG_2  = 8'h0c;
  localparam logic [7:0] OFF_RESULT_0      = 8'h10;
  localparam logic [7:0] OFF_RESULT_1      = 8'h14;
  localparam logic [7:0] OFF_COMPARE_1     = 8'h18;
  localparam logic [7:0] OFF_COMPARE_2     = 8'h1c;
  localparam logic [7:0] OFF_STATUS_CTRL_2 = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS    = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h28;
  localparam logic [7:0] RES_STRIDE        = 8'h04;
  // channel control fields
  localparam int         CH_LSB        = 0;
  localparam int         CH_W          = 5;
  localparam int         CC_SIGNED_BIT = 5;
  localparam int         CC_DONE_BIT   = 7;
  localparam logic [4:0] CH_DISABLED   = 5'h1f;
  // timing config one fields
  localparam int CF1_MODE_LSB  = 2;
  localparam int CF1_LSMP_BIT  = 4;
  // timing config two fields
  localparam int CF2_LSTS_LSB  = 0;
  localparam int CF2_HSC_BIT   = 2;
  // status control two fields
  localparam int SC2_RNG_BIT   = 3;
  localparam int SC2_GT_BIT    = 4;
  localparam int SC2_CFE_BIT   = 5;
  localparam int SC2_TRG_BIT   = 6;
  localparam int SC2_ACT_BIT   = 7;
  // writable masks
  localparam logic [31:0] MASK_CHAN_CTRL = 32'h0000_003f;
  localparam logic [31:0] MASK_CFG_1     = 32'h0000_001c;
  localparam logic [31:0] MASK_CFG_2     = 32'h0000_0007;
  localparam logic [31:0] MASK_SC2       = 32'h0000_0078;
  localparam logic [31:0] MASK_VALUE     = 32'h0000_ffff;
  localparam logic [31:0] MASK_IRQ       = 32'h0000_0003;
  localparam logic [31:0] RESET_CHAN     = 32'h0000_001f;
  // resolution codes
  localparam logic [1:0] MODE_8  = 2'b00;
  localparam logic [1:0] MODE_12 = 2'b01;
  localparam logic [1:0] MODE_10 = 2'b10;
  // cycle counts in conversion clocks
  localparam int SAMPLE_BASE  = 4;
  localparam int EXTRA_LS_00  = 20;
  localparam int EXTRA_LS_01  = 12;
  localparam int EXTRA_LS_10  = 6;
  localparam int EXTRA_LS_11  = 2;
  localparam int EXTRA_HS     = 2;
  localparam int CONV_DEFAULT = 20;
  typedef enum logic [1:0] {
    ATC_IDLE    = 2'b00,
    ATC_SAMPLE  = 2'b01,
    ATC_CONVERT = 2'b11
  } atc_state_t;
endpackage

// ===== hw/atc_core.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module atc_core
  import atc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_DEFAULT
)(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [31:0] RD_DATA,
  input  wire logic        HW_TRIGGER,
  input  wire logic [1:0]  HW_TRIGGER_SELECT,
  input  wire logic [15:0] CONV_DATA,
  output logic             CONV_SAMPLE,
  output logic             CONV_BUSY,
  output logic      [4:0]  CONV_CHANNEL,
  output logic             IRQ
);
  initial begin
    if (CONV_CYCLES < 1 || CONV_CYCLES > 200)
      $error("CONV_CYCLES out of range");
  end

  function automatic logic [15:0] fmt_value(input logic [15:0] v, input logic [1:0] mode,
                                            input logic sgn);
    logic [15:0] r;
    r = v;
    case (mode)
      MODE_12: r = sgn ? {{4{v[11]}}, v[11:0]} : {4'h0, v[11:0]};
      MODE_10: r = sgn ? {{6{v[9]}}, v[9:0]} : {6'h00, v[9:0]};
      default: r = sgn ? {{8{v[7]}}, v[7:0]} : {8'h00, v[7:0]};
    endcase
    return r;
  endfunction

  function automatic logic [5:0] sample_len(input logic ls, input logic [1:0] sel);
    logic [5:0] n;
    n = 6'(SAMPLE_BASE);
    if (ls)
    begin
      case (sel)
        2'b00:   n = 6'(SAMPLE_BASE + EXTRA_LS_00);
        2'b01:   n = 6'(SAMPLE_BASE + EXTRA_LS_01);
        2'b10:   n = 6'(SAMPLE_BASE + EXTRA_LS_10);
        default: n = 6'(SAMPLE_BASE + EXTRA_LS_11);
      endcase
    end
    return n;
  endfunction

  function automatic logic lt16(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    return sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  // register state
  logic [5:0]  chan_reg [2];
  logic [5:0]  chan_next [2];
  logic [1:0]  done_reg, done_next;
  logic [2:0]  timing_config_one_reg, timing_config_one_next;
  logic [2:0]  timing_config_two_reg_reg, timing_config_two_reg_next;
  logic [15:0] result_reg [2];
  logic [15:0] result_next [2];
  logic [15:0] cv_reg [2];
  logic [15:0] cv_next [2];
  logic [3:0]  sc2_reg, sc2_next;
  logic [1:0]  ists_reg, ists_next;
  logic [1:0]  imask_reg, imask_next;
  logic [31:0] rd_data_reg, rd_data_next;
  logic        irq_reg, irq_next;
  // sequencer state
  atc_state_t  state_reg, state_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic        slot_reg, slot_next;
  logic        hs_reg, hs_next;
  logic        sgn_reg, sgn_next;
  logic [1:0]  mode_reg, mode_next;
  logic        armed_reg, armed_next;
  logic        arm_slot_reg, arm_slot_next;
  // pin synchronisers
  logic [1:0]  trg_s1_reg;
  logic        trg_s2_reg, trg_s3_reg;
  logic [1:0]  sel_s1_reg [2];
  logic [1:0]  sel_s2_reg [2];

  logic        wr_chan0, wr_chan1, trg_hw, sw_start, hw_start, start, abort, finish;
  logic [15:0] res_fmt, cv1_fmt, cv2_fmt, lo_v, hi_v;
  logic        cmp_ok, res_we;
  logic [7:0]  conv_len;

  assign wr_chan0 = WR_STB && ADDR == OFF_CHAN_CTRL_0;
  assign wr_chan1 = WR_STB && ADDR == OFF_CHAN_CTRL_1;
  assign trg_hw   = sc2_reg[SC2_TRG_BIT - SC2_RNG_BIT];
  assign conv_len = 8'(CONV_CYCLES) + (hs_reg ? 8'(EXTRA_HS) : 8'h00);

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      trg_s1_reg    <= 2'h0;
      trg_s2_reg    <= 1'b0;
      trg_s3_reg    <= 1'b0;
      sel_s1_reg[0] <= 2'h0;
      sel_s1_reg[1] <= 2'h0;
      sel_s2_reg[0] <= 2'h0;
      sel_s2_reg[1] <= 2'h0;
    end
    else if (CLK_EN)
    begin
      trg_s1_reg    <= {trg_s1_reg[0], HW_TRIGGER};
      trg_s2_reg    <= trg_s1_reg[1];
      trg_s3_reg    <= trg_s2_reg;
      sel_s1_reg[0] <= HW_TRIGGER_SELECT;
      sel_s1_reg[1] <= sel_s1_reg[0];
      sel_s2_reg[0] <= sel_s1_reg[1];
      sel_s2_reg[1] <= sel_s2_reg[0];
    end
  end

  // trigger start: software by first channel write, hardware by edge after select pulse
  assign sw_start = !trg_hw && wr_chan0 && WR_DATA[CH_W-1:0] != CH_DISABLED;
  assign hw_start = trg_hw && armed_reg && trg_s2_reg && !trg_s3_reg
                    && chan_reg[arm_slot_reg][CH_W-1:0] != CH_DISABLED;
  assign abort    = state_reg != ATC_IDLE &&
                    ((wr_chan0 && !sw_start) || (wr_chan0 && sw_start) ||
                     (WR_STB && ADDR == OFF_STATUS_CTRL_2));
  assign start    = sw_start || (hw_start && state_reg == ATC_IDLE);
  assign finish   = state_reg == ATC_CONVERT && cnt_reg == 8'h00 && !abort;

  // compare: result and values share format, only active mode bits count
  assign res_fmt = fmt_value(CONV_DATA, mode_reg, sgn_reg);
  assign cv1_fmt = fmt_value(cv_reg[0], mode_reg, sgn_reg);
  assign cv2_fmt = fmt_value(cv_reg[1], mode_reg, sgn_reg);
  assign lo_v    = lt16(cv2_fmt, cv1_fmt, sgn_reg) ? cv2_fmt : cv1_fmt;
  assign hi_v    = lt16(cv2_fmt, cv1_fmt, sgn_reg) ? cv1_fmt : cv2_fmt;

  always_comb
  begin
    cmp_ok = 1'b1;
    if (sc2_reg[SC2_CFE_BIT - SC2_RNG_BIT])
    begin
      if (!sc2_reg[0])
        cmp_ok = sc2_reg[SC2_GT_BIT - SC2_RNG_BIT] ? !lt16(res_fmt, cv1_fmt, sgn_reg)
                                                   : lt16(res_fmt, cv1_fmt, sgn_reg);
      else if (sc2_reg[SC2_GT_BIT - SC2_RNG_BIT])
        cmp_ok = !lt16(res_fmt, lo_v, sgn_reg) && !lt16(hi_v, res_fmt, sgn_reg);
      else
        cmp_ok = lt16(res_fmt, lo_v, sgn_reg) || lt16(hi_v, res_fmt, sgn_reg);
    end
  end
  assign res_we = finish && cmp_ok;

  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    slot_next     = slot_reg;
    hs_next       = hs_reg;
    sgn_next      = sgn_reg;
    mode_next     = mode_reg;
    armed_next    = armed_reg;
    arm_slot_next = arm_slot_reg;
    if (sel_s2_reg[1][0] || sel_s2_reg[1][1])
    begin
      armed_next    = 1'b1;
      arm_slot_next = sel_s2_reg[1][1];
    end
    if (start)
    begin
      state_next = ATC_SAMPLE;
      slot_next  = sw_start ? 1'b0 : arm_slot_reg;
      hs_next    = timing_config_two_reg_reg[CF2_HSC_BIT];
      mode_next  = timing_config_one_reg[CF1_MODE_LSB-2 +: 2];
      sgn_next   = sw_start ? WR_DATA[CC_SIGNED_BIT] : chan_reg[arm_slot_reg][CC_SIGNED_BIT];
      cnt_next   = {2'b00, sample_len(timing_config_one_reg[CF1_LSMP_BIT-2],
                                      timing_config_two_reg_reg[CF2_LSTS_LSB +: 2])} - 8'h01;
      if (hw_start)
        armed_next = 1'b0;
    end
    else if (abort)
      state_next = ATC_IDLE;
    else
    begin
      case (state_reg)
        ATC_SAMPLE:
        begin
          if (cnt_reg == 8'h00)
          begin
            state_next = ATC_CONVERT;
            cnt_next   = conv_len - 8'h01;
          end
          else
            cnt_next = cnt_reg - 8'h01;
        end
        ATC_CONVERT:
        begin
          if (cnt_reg == 8'h00)
            state_next = ATC_IDLE;
          else
            cnt_next = cnt_reg - 8'h01;
        end
        default: state_next = ATC_IDLE;
      endcase
    end
  end

  always_comb
  begin
    chan_next    = chan_reg;
    done_next    = done_reg;
    timing_config_one_next    = timing_config_one_reg;
    timing_config_two_reg_next    = timing_config_two_reg_reg;
    result_next  = result_reg;
    cv_next      = cv_reg;
    sc2_next     = sc2_reg;
    imask_next   = imask_reg;
    ists_next    = ists_reg;
    rd_data_next = 32'h0000_0000;
    if (WR_STB)
    begin
      // reserved bits masked, result addresses have no write path
      case (ADDR)
        OFF_CHAN_CTRL_0:   chan_next[0] = WR_DATA[5:0] & MASK_CHAN_CTRL[5:0];
        OFF_CHAN_CTRL_1:   chan_next[1] = WR_DATA[5:0] & MASK_CHAN_CTRL[5:0];
        OFF_TIMING_CFG_1:  timing_config_one_next = WR_DATA[4:2] & MASK_CFG_1[4:2];
        OFF_TIMING_CFG_2:  timing_config_two_reg_next = WR_DATA[2:0] & MASK_CFG_2[2:0];
        OFF_COMPARE_1:     cv_next[0] = WR_DATA[15:0] & MASK_VALUE[15:0];
        OFF_COMPARE_2:     cv_next[1] = WR_DATA[15:0] & MASK_VALUE[15:0];
        OFF_STATUS_CTRL_2: sc2_next = WR_DATA[6:3] & MASK_SC2[6:3];
        OFF_IRQ_STATUS:    ists_next = ists_reg & ~(WR_DATA[1:0] & MASK_IRQ[1:0]);
        OFF_IRQ_MASK:      imask_next = WR_DATA[1:0] & MASK_IRQ[1:0];
        default:           ;
      endcase
    end
    if (wr_chan0)
      done_next[0] = 1'b0;
    if (wr_chan1)
      done_next[1] = 1'b0;
    if (res_we)
    begin
      result_next[slot_reg] = res_fmt;
      done_next[slot_reg]   = 1'b1;
      ists_next[slot_reg]   = 1'b1;
    end
    if (RD_STB)
    begin
      case (ADDR)
        OFF_CHAN_CTRL_0:   rd_data_next = {24'h0, done_reg[0], 1'b0, chan_reg[0]};
        OFF_CHAN_CTRL_1:   rd_data_next = {24'h0, done_reg[1], 1'b0, chan_reg[1]};
        OFF_TIMING_CFG_1:  rd_data_next = {27'h0, timing_config_one_reg, 2'b00};
        OFF_TIMING_CFG_2:  rd_data_next = {29'h0, timing_config_two_reg_reg};
        OFF_RESULT_0:      rd_data_next = {16'h0, result_reg[0]};
        OFF_RESULT_0 + RES_STRIDE:
                           rd_data_next = {16'h0, result_reg[1]};
        OFF_COMPARE_1:     rd_data_next = {16'h0, cv_reg[0]};
        OFF_COMPARE_1 + RES_STRIDE:
                           rd_data_next = {16'h0, cv_reg[1]};
        OFF_STATUS_CTRL_2: rd_data_next = {24'h0, state_reg != ATC_IDLE,
                                           sc2_reg, 3'b000};
        OFF_IRQ_STATUS:    rd_data_next = {30'h0, ists_reg};
        OFF_IRQ_MASK:      rd_data_next = {30'h0, imask_reg};
        default:           rd_data_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(ists_next & imask_next);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      chan_reg[0]   <= RESET_CHAN[5:0];
      chan_reg[1]   <= RESET_CHAN[5:0];
      done_reg      <= 2'h0;
      timing_config_one_reg      <= 3'h0;
      timing_config_two_reg_reg      <= 3'h0;
      result_reg[0] <= 16'h0000;
      result_reg[1] <= 16'h0000;
      cv_reg[0]     <= 16'h0000;
      cv_reg[1]     <= 16'h0000;
      sc2_reg       <= 4'h0;
      ists_reg      <= 2'h0;
      imask_reg     <= 2'h0;
      rd_data_reg   <= 32'h0000_0000;
      irq_reg       <= 1'b0;
      state_reg     <= ATC_IDLE;
      cnt_reg       <= 8'h00;
      slot_reg      <= 1'b0;
      hs_reg        <= 1'b0;
      sgn_reg       <= 1'b0;
      mode_reg      <= MODE_8;
      armed_reg     <= 1'b0;
      arm_slot_reg  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      chan_reg      <= chan_next;
      done_reg      <= done_next;
      timing_config_one_reg      <= timing_config_one_next;
      timing_config_two_reg_reg      <= timing_config_two_reg_next;
      result_reg    <= result_next;
      cv_reg        <= cv_next;
      sc2_reg       <= sc2_next;
      ists_reg      <= ists_next;
      imask_reg     <= imask_next;
      rd_data_reg   <= rd_data_next;
      irq_reg       <= irq_next;
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      slot_reg      <= slot_next;
      hs_reg        <= hs_next;
      sgn_reg       <= sgn_next;
      mode_reg      <= mode_next;
      armed_reg     <= armed_next;
      arm_slot_reg  <= arm_slot_next;
    end
  end

  // converter-facing outputs follow the registered sequencer
  logic       samp_reg, busy_reg;
  logic [4:0] chsel_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      samp_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      chsel_reg <= CH_DISABLED;
    end
    else if (CLK_EN)
    begin
      samp_reg  <= state_next == ATC_SAMPLE;
      busy_reg  <= state_next != ATC_IDLE;
      chsel_reg <= start ? (sw_start ? WR_DATA[4:0] : chan_reg[arm_slot_reg][4:0])
                         : chsel_reg;
    end
  end

  assign RD_DATA      = rd_data_reg;
  assign IRQ          = irq_reg;
  assign CONV_SAMPLE  = samp_reg;
  assign CONV_BUSY    = busy_reg;
  assign CONV_CHANNEL = chsel_reg;

  // helper: cycles spent in current phase
  logic [7:0] phase_cnt;
  logic [5:0] exp_sample;
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      phase_cnt <= 8'h00;
    else if (CLK_EN)
      phase_cnt <= (state_next != state_reg || start) ? 8'h00 : phase_cnt + 8'h01;
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      exp_sample <= 6'h00;
    else if (CLK_EN && start)
      exp_sample <= !timing_config_one_reg[CF1_LSMP_BIT-2] ? 6'd4 :
                    timing_config_two_reg_reg[1:0] == 2'b00 ? 6'd24 : timing_config_two_reg_reg[1:0] == 2'b01 ? 6'd16 :
                    timing_config_two_reg_reg[1:0] == 2'b10 ? 6'd10 : 6'd6;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_chan0_write;
    CLK_EN && wr_chan0 && !trg_hw && WR_DATA[4:0] != CH_DISABLED;
  endsequence
  sequence s_sampling;
    state_reg == ATC_SAMPLE && CONV_SAMPLE == 1'b1;
  endsequence

  chk_hs_conv_len: assert property (CLK_EN && finish |->
      phase_cnt == (hs_reg ? 8'(CONV_CYCLES + 1) : 8'(CONV_CYCLES - 1)))
    else $error("conversion phase length wrong");
  chk_sample_len: assert property (CLK_EN && !abort && !start &&
      state_reg == ATC_SAMPLE && state_next == ATC_CONVERT |->
      phase_cnt == 8'(exp_sample) - 8'h01)
    else $error("sample phase length wrong");
  chk_short_sample: assert property (s_chan0_write ##1 s_sampling
      |-> exp_sample == 6'd4 || $past(timing_config_one_reg[CF1_LSMP_BIT-2]))
    else $error("long sample applied outside long mode");
  chk_unsigned_zero: assert property (CLK_EN && res_we && !sgn_reg && mode_reg == MODE_8
      |=> result_reg[$past(slot_reg)][15:8] == 8'h00)
    else $error("unsigned upper bits not zero");
  chk_sign_copy: assert property (CLK_EN && res_we && sgn_reg && mode_reg == MODE_12
      |=> result_reg[$past(slot_reg)][15:12] == {4{result_reg[$past(slot_reg)][11]}})
    else $error("sign bits not copied");
  chk_result_upper: assert property (CLK_EN && RD_STB &&
      (ADDR == OFF_RESULT_0 || ADDR == OFF_RESULT_1) |=> RD_DATA[31:16] == 16'h0000)
    else $error("result upper half not zero");
  chk_active_flag: assert property (CLK_EN && RD_STB && ADDR == OFF_STATUS_CTRL_2
      |=> RD_DATA[SC2_ACT_BIT] == ($past(state_reg) != ATC_IDLE))
    else $error("active flag mismatch");
  chk_sw_start: assert property (s_chan0_write |=> state_reg == ATC_SAMPLE
      ##1 CONV_SAMPLE)
    else $error("software trigger did not start");
  chk_cmp_gate: assert property (CLK_EN && finish && !sc2_reg[2]
      |=> done_reg[$past(slot_reg)])
    else $error("result dropped with compare off");
  chk_ro_result: assert property (CLK_EN && WR_STB && ADDR == OFF_RESULT_0 &&
      !(res_we && !slot_reg) |=> $stable(result_reg[0]))
    else $error("write changed result register");
  chk_irq_level: assert property (CLK_EN |=>
      IRQ == |($past(ists_next) & $past(imask_next)))
    else $error("interrupt level wrong");
endmodule // atc_core

// ===== tb/adc_timing_result_compare_regs_test.sv
`timescale 1ns/1ps
module adc_timing_result_compare_regs_test
  import atc_pkg::*;
;
  localparam int CC = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [31:0] rdata;
  logic        hw_trg = 1'b0;
  logic [1:0]  hw_sel = 2'b00;
  logic [15:0] raw = 16'h0000;
  logic        sample;
  logic        busy;
  logic        irq;
  logic [4:0]  chan;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  int          ns;
  int          nb;
  int          ls [4] = '{24, 16, 10, 6};
  logic [1:0]  md [3] = '{MODE_12, MODE_10, MODE_8};
  logic [31:0] fx [3] = '{32'h0fff, 32'h03ff, 32'h00ff};
  logic [7:0]  sc [9] = '{8'h20, 8'h20, 8'h30, 8'h30, 8'h38, 8'h38, 8'h28, 8'h28, 8'h10};
  logic [15:0] rv [9] = '{16'h080, 16'h100, 16'h100, 16'h080, 16'h080, 16'h100, 16'h080,
                          16'h020, 16'h020};
  logic [8:0]  okv = 9'b110110101;

  atc_core #(.CONV_CYCLES(CC)) u_dut (
    .SYS_CLK(clk), .RESET(rst), .CLK_EN(en), .ADDR(addr), .WR_DATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rdata), .HW_TRIGGER(hw_trg),
    .HW_TRIGGER_SELECT(hw_sel), .CONV_DATA(raw), .CONV_SAMPLE(sample),
    .CONV_BUSY(busy), .CONV_CHANNEL(chan), .IRQ(irq)
  );

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
  endtask

  // counts busy and sample cycles of one conversion
  task wait_conv;
    ns = 0;
    nb = 0;
    @(negedge clk);
    for (int i = 0; i < 10 && busy !== 1'b1; i++)
      @(negedge clk);
    while (busy === 1'b1 && nb < 100)
    begin
      nb++;
      ns += int'(sample === 1'b1);
      @(negedge clk);
    end
  endtask

  task conv(input logic [31:0] cc);
    wr(OFF_CHAN_CTRL_0, cc);
    wait_conv();
  endtask

  task end_test(input string nm);
    $display("test %s finished", nm);
  endtask

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(OFF_COMPARE_1, 32'hffff_ffff);
    rd(OFF_COMPARE_1, 32'h0000_ffff, "cv1");
    wr(OFF_COMPARE_2, 32'h1234_5678);
    rd(OFF_COMPARE_2, 32'h0000_5678, "cv2");
    wr(OFF_TIMING_CFG_2, 32'hffff_ffff);
    rd(OFF_TIMING_CFG_2, 32'h0000_0007, "timing_config_two_reg");
    rd(8'h30, 32'h0, "unmapped");
    end_test("regs");
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        wr(OFF_TIMING_CFG_1, {27'h0, m[0], MODE_12, 2'b00});
        wr(OFF_TIMING_CFG_2, {29'h0, m[0] ^ c[0], c[1:0]});
        conv(32'h3);
        chk("sample", (m == 1) ? ls[c] : 4, ns);
        chk("busy", ((m == 1) ? ls[c] : 4) + CC + 2 * (m ^ c[0]), nb);
      end
    end_test("timing");
    raw <= 16'hffff;
    wr(OFF_TIMING_CFG_2, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_TIMING_CFG_1, {28'h0, md[i], 2'b00});
      conv(32'h3);
      rd(OFF_RESULT_0, fx[i], "result0");
    end
    conv(32'h23);
    rd(OFF_RESULT_0, 32'h0000_ffff, "signed");
    wr(OFF_RESULT_0, 32'h0);
    rd(OFF_RESULT_0, 32'h0000_ffff, "result ro");
    end_test("format");
    wr(OFF_CHAN_CTRL_0, 32'h3);
    rd(OFF_STATUS_CTRL_2, 32'h80, "active");
    repeat (20) @(negedge clk);
    rd(OFF_STATUS_CTRL_2, 32'h0, "done");
    wr(OFF_CHAN_CTRL_0, 32'h3);
    wr(OFF_CHAN_CTRL_0, 32'h1f);
    rd(OFF_STATUS_CTRL_2, 32'h0, "abort");
    end_test("active");
    wr(OFF_TIMING_CFG_1, {28'h0, MODE_12, 2'b00});
    wr(OFF_COMPARE_1, 32'h100);
    wr(OFF_COMPARE_2, 32'h050);
    for (int i = 0; i < 9; i++)
    begin
      wr(OFF_STATUS_CTRL_2, 32'h0);
      raw <= 16'h0777;
      conv(32'h3);
      wr(OFF_STATUS_CTRL_2, {24'h0, sc[i]});
      raw <= rv[i];
      conv(32'h3);
      rd(OFF_RESULT_0, {16'h0, okv[i] ? rv[i] : 16'h0777}, "compare");
    end
    wr(OFF_STATUS_CTRL_2, 32'h0);
    end_test("compare");
    wr(OFF_IRQ_STATUS, 32'h3);
    wr(OFF_IRQ_MASK, 32'h0);
    conv(32'h3);
    rd(OFF_IRQ_STATUS, 32'h1, "irq status");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    end_test("irq");
    wr(OFF_STATUS_CTRL_2, 32'h40);
    wr(OFF_CHAN_CTRL_1, 32'h5);
    raw    <= 16'h0123;
    hw_sel <= 2'b10;
    repeat (3) @(posedge clk);
    hw_sel <= 2'b00;
    repeat (4) @(posedge clk);
    hw_trg <= 1'b1;
    wait_conv();
    @(posedge clk);
    hw_trg <= 1'b0;
    chk("busy hw", 4 + CC, nb);
    rd(OFF_RESULT_1, 32'h0123, "result1");
    rd(OFF_RESULT_0, 32'h0020, "result0 kept");
    chk("channel", 32'h5, {27'h0, chan});
    rd(OFF_STATUS_CTRL_2, 32'h40, "trigger sel");
    end_test("hwtrig");
    wr(OFF_STATUS_CTRL_2, 32'h0);
    wr(OFF_CHAN_CTRL_0, 32'h3);
    en <= 1'b0;
    repeat (30) @(negedge clk);
    chk("frozen sample", 32'h1, {31'h0, sample});
    chk("frozen busy", 32'h1, {31'h0, busy});
    @(posedge clk);
    en <= 1'b1;
    repeat (20) @(negedge clk);
    rd(OFF_STATUS_CTRL_2, 32'h0, "thawed");
    end_test("clock enable");
    report_and_stop();
  end
endmodule // adc_timing_result_compare_regs_test
